// ### core/rsc_top.sv
// Purpose: Core buck slew control and linear rail set-point register
// Assumes: Register strobes come from the serial-bus back end
// Notes:   Long counts are parameters so simulation can shorten them
`timescale 1ns/1ns
`include "rsc_params.svh"

module rsc_top #(
  parameter int STEP_BASE_CYC = `RSC_STEP_BASE_CYC,
  parameter int BLANK_CYC     = `RSC_BLANK_CYC,
  parameter rsc_pkg::rsc_code_t A_RST_CODE = 6'h00,
  parameter rsc_pkg::rsc_code_t B_RST_CODE = 6'h00
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // Register access
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  input  wire logic               pwd_unlocked,
  // Core buck set-point registers
  input  wire rsc_pkg::rsc_code_t core_buck_a_setpoint,
  input  wire logic               core_buck_a_wr,
  input  wire rsc_pkg::rsc_code_t core_buck_b_setpoint,
  input  wire logic               core_buck_b_wr,
  // Applied core buck codes
  output rsc_pkg::rsc_code_t      core_buck_a_code,
  output rsc_pkg::rsc_code_t      core_buck_b_code,
  output logic                    ramp_busy,
  // Linear rail
  output rsc_pkg::rsc_code_t      linear_rail_code,
  output logic [11:0]             linear_rail_mv,
  output logic                    linear_rail_mon_blank
);

  // ==========================================================
  // Register state
  logic               go;
  logic               next_go;
  logic               go_arm;
  logic               next_go_arm;
  logic               auto_apply_setpoint;
  logic               next_auto_apply_setpoint;
  logic [2:0]         ramp_rate;
  logic [2:0]         next_ramp_rate;
  rsc_pkg::rsc_code_t next_linear_rail_code;
  logic [7:0]         next_reg_rdata;

  logic               wr_ramp;
  logic               wr_lin;
  logic               go_start;
  logic               start_a;
  logic               start_b;
  logic               busy_a;
  logic               busy_b;
  logic               imm;
  logic               go_done;
  logic [15:0]        dwell;
  logic [15:0]        dwell_raw;
  rsc_pkg::rsc_code_t code_a;
  rsc_pkg::rsc_code_t code_b;

  assign wr_ramp  = reg_wr && (reg_addr == `RSC_OFS_RAMP_CTRL);
  assign wr_lin   = reg_wr && (reg_addr == `RSC_OFS_LIN_RAIL) && pwd_unlocked;
  assign go_start = wr_ramp && reg_wdata[`RSC_GO_BIT];

  // ==========================================================
  // Ramp launch
  // Each base halving per code; never below one cycle
  assign dwell_raw = 16'(STEP_BASE_CYC >> ramp_rate);
  assign dwell     = (dwell_raw == '0) ? 16'h0001 : dwell_raw;
  assign imm       = (ramp_rate == `RSC_RATE_IMM);
  // Only the two core buck rails are driven by this logic
  assign start_a   = go_start || (auto_apply_setpoint && core_buck_a_wr);
  assign start_b   = go_start || (auto_apply_setpoint && core_buck_b_wr);
  // go_arm masks completion in the cycle go rises, the same cycle the rails first report busy
  assign go_done   = go && !go_arm && !busy_a && !busy_b;

  rsc_ramp_rail #(
    .DW       (16),
    .RST_CODE (A_RST_CODE)
  ) u_rail_a (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .start     (start_a),
    .target_in (core_buck_a_setpoint),
    .immediate (imm),
    .dwell     (dwell),
    .code      (code_a),
    .busy      (busy_a)
  );

  rsc_ramp_rail #(
    .DW       (16),
    .RST_CODE (B_RST_CODE)
  ) u_rail_b (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .start     (start_b),
    .target_in (core_buck_b_setpoint),
    .immediate (imm),
    .dwell     (dwell),
    .code      (code_b),
    .busy      (busy_b)
  );

  // Rails sit at their reset codes until the first launch
  logic launched_a;
  logic launched_b;
  logic next_launched_a;
  logic next_launched_b;

  assign next_launched_a  = launched_a || start_a;
  assign next_launched_b  = launched_b || start_b;
  assign core_buck_a_code = launched_a ? code_a : A_RST_CODE;
  assign core_buck_b_code = launched_b ? code_b : B_RST_CODE;
  assign ramp_busy        = busy_a || busy_b;

  // ==========================================================
  // Linear rail map
  always_comb
  begin
    if (linear_rail_code < `RSC_LIN_BREAK)
      linear_rail_mv = `RSC_LIN_LO_MV + `RSC_LIN_LO_STEP * 12'(linear_rail_code);
    else
      linear_rail_mv = `RSC_LIN_HI_MV
                     + `RSC_LIN_HI_STEP * 12'(linear_rail_code - `RSC_LIN_BREAK);
  end

  rsc_blank_timer #(
    .CYC (BLANK_CYC)
  ) u_blank (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .start   (wr_lin),
    .active  (linear_rail_mon_blank)
  );

  // ==========================================================
  // Register next values
  always_comb
  begin
    next_go                  = go;
    next_go_arm              = go_start;
    next_auto_apply_setpoint = auto_apply_setpoint;
    next_ramp_rate           = ramp_rate;
    next_linear_rail_code    = linear_rail_code;
    next_reg_rdata           = reg_rdata;
    // Completion clears, a new trigger in the same cycle wins
    if (go_done)
      next_go = 1'b0;
    if (go_start)
      next_go = 1'b1;
    if (wr_ramp)
    begin
      // Bits 5:3 dropped on write
      next_auto_apply_setpoint = reg_wdata[`RSC_AUTO_BIT];
      next_ramp_rate           = reg_wdata[`RSC_RATE_MSB:0];
    end
    if (wr_lin)
      next_linear_rail_code = reg_wdata[`RSC_LIN_MSB:0];
    if (reg_rd)
    begin
      case (reg_addr)
        `RSC_OFS_RAMP_CTRL:
          next_reg_rdata = {go, auto_apply_setpoint, 3'b000, ramp_rate};
        `RSC_OFS_LIN_RAIL:
          next_reg_rdata = {2'b00, linear_rail_code};
        default:
          next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      go                  <= 1'b0;
      go_arm              <= 1'b0;
      auto_apply_setpoint <= 1'(`RSC_RAMP_CTRL_RST >> `RSC_AUTO_BIT);
      ramp_rate           <= 3'(`RSC_RAMP_CTRL_RST);
      linear_rail_code    <= `RSC_LIN_RAIL_RST;
      reg_rdata           <= 8'h00;
      launched_a          <= 1'b0;
      launched_b          <= 1'b0;
    end
    else
    begin
      go                  <= next_go;
      go_arm              <= next_go_arm;
      auto_apply_setpoint <= next_auto_apply_setpoint;
      ramp_rate           <= next_ramp_rate;
      linear_rail_code    <= next_linear_rail_code;
      reg_rdata           <= next_reg_rdata;
      launched_a          <= next_launched_a;
      launched_b          <= next_launched_b;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_go_set;
    go_start |=> go ##1 (go || !ramp_busy);
  endproperty
  a_go_set: assert property (p_go_set) else $error("trigger write did not set go");

  property p_go_zero;
    (wr_ramp && !reg_wdata[7] && !go && !auto_apply_setpoint && !ramp_busy) |=> !go && !$changed(core_buck_a_code);
  endproperty
  a_go_zero: assert property (p_go_zero) else $error("zero trigger changed state");

  property p_go_clear;
    (go && !go_arm && !ramp_busy && !go_start) |=> !go;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go not cleared at end");

  property p_auto;
    (auto_apply_setpoint && core_buck_a_wr && !imm && core_buck_a_setpoint != code_a) |=> busy_a;
  endproperty
  a_auto: assert property (p_auto) else $error("auto apply did not start ramp");

  property p_no_auto;
    (!auto_apply_setpoint && !go_start && !busy_a && core_buck_a_wr) |=> !busy_a && $stable(code_a);
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("set-point moved without trigger");

  property p_rate_rst;
    $fell(sys_rst) |-> ramp_rate == 3'h6 && !go && !auto_apply_setpoint;
  endproperty
  a_rate_rst: assert property (@(posedge mclk) p_rate_rst) else $error("bad ramp reset");

  property p_imm;
    (start_a && imm) |=> code_a == $past(core_buck_a_setpoint) && !busy_a;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate code not applied");

  property p_step;
    (busy_a && !start_a) |=> (code_a == $past(code_a)) || (code_a == $past(code_a) + 6'h01)
                             || (code_a == $past(code_a) - 6'h01);
  endproperty
  a_step: assert property (p_step) else $error("ramp moved more than one code");

  property p_blank;
    wr_lin |=> linear_rail_mon_blank [*8];
  endproperty
  a_blank: assert property (p_blank) else $error("monitor not blanked");

  property p_lock;
    (reg_wr && reg_addr == 8'h1b && !pwd_unlocked) |=> $stable(linear_rail_code) && !$rose(linear_rail_mon_blank);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write took effect");

  property p_map;
    (linear_rail_code == 6'h3f) |-> linear_rail_mv == 12'hd48;
  endproperty
  a_map: assert property (p_map) else $error("linear map top code wrong");

  property p_rsvd;
    (reg_rd && reg_addr == 8'h1a) |=> reg_rdata[5:3] == 3'b000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

  // Trigger must not drop while either rail is still stepping
  property p_go_hold;
    (go && ramp_busy) |=> go;
  endproperty
  a_go_hold: assert property (p_go_hold) else $error("go cleared during ramp");

  property p_lin_only;
    !wr_lin |=> $stable(linear_rail_code);
  endproperty
  a_lin_only: assert property (p_lin_only) else $error("linear rail moved without write");

  property p_rsvd_lin;
    (reg_rd && reg_addr == 8'h1b) |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_rsvd_lin: assert property (p_rsvd_lin) else $error("linear reserved bits nonzero");

  c_go_ramp: cover property (go_start && !imm ##[1:20] go_done);
  c_auto:    cover property (auto_apply_setpoint && core_buck_b_wr && !imm);
  c_imm:     cover property (go_start && imm);
  c_lin:     cover property (wr_lin ##1 wr_lin);

endmodule

// ### include/rsc_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz mclk
// Notes:   Definitions only
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ==========================================================
// Register offsets and reset values
`define RSC_OFS_RAMP_CTRL 8'h1a
`define RSC_OFS_LIN_RAIL  8'h1b
`define RSC_RAMP_CTRL_RST 8'h06
`define RSC_LIN_RAIL_RST  6'h1f

// ==========================================================
// Field positions and codes
`define RSC_GO_BIT        7
`define RSC_AUTO_BIT      6
`define RSC_RATE_MSB      2
`define RSC_LIN_MSB       5
`define RSC_RATE_IMM      3'h7

// ==========================================================
// Linear rail code map
`define RSC_LIN_BREAK     6'h1a
`define RSC_LIN_LO_MV     12'h384
`define RSC_LIN_LO_STEP   12'h019
`define RSC_LIN_HI_MV     12'h60e
`define RSC_LIN_HI_STEP   12'h032

// ==========================================================
// Timing
`define RSC_CLK_PERIOD_NS 20
`define RSC_STEP_BASE_NS  160000
`define RSC_STEP_BASE_CYC (`RSC_STEP_BASE_NS / `RSC_CLK_PERIOD_NS)
`define RSC_BLANK_MS      5
`define RSC_BLANK_CYC     (`RSC_BLANK_MS * 1000000 / `RSC_CLK_PERIOD_NS)

`endif

// ### include/rsc_pkg.sv
// Purpose: Shared types of the rail set-point block
// Assumes: Nothing
// Notes:   Constants live in rsc_params.svh
package rsc_pkg;

  // ==========================================================
  // Types
  typedef logic [5:0] rsc_code_t;

  typedef enum logic {
    RSC_IDLE,
    RSC_RAMP
  } rsc_rail_state_t;

endpackage

// ### core/rsc_ramp_rail.sv
// Purpose: One core buck set-point stepper
// Assumes: dwell is at least 1
// Notes:   A start while ramping retargets on the fly
`timescale 1ns/1ns
module rsc_ramp_rail #(
  parameter int                 DW       = 16,
  parameter rsc_pkg::rsc_code_t RST_CODE = 6'h00
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Request
  input  wire logic             start,
  input  wire rsc_pkg::rsc_code_t target_in,
  input  wire logic             immediate,
  input  wire logic [DW-1:0]    dwell,
  // Result
  output rsc_pkg::rsc_code_t    code,
  output logic                  busy
);

  // ==========================================================
  // Stepper
  rsc_pkg::rsc_rail_state_t state;
  rsc_pkg::rsc_rail_state_t next_state;
  rsc_pkg::rsc_code_t       target;
  rsc_pkg::rsc_code_t       next_target;
  rsc_pkg::rsc_code_t       next_code;
  logic [DW-1:0]            cnt;
  logic [DW-1:0]            next_cnt;

  always_comb
  begin
    next_state  = state;
    next_target = target;
    next_code   = code;
    next_cnt    = cnt;
    if (start)
    begin
      next_target = target_in;
      if (immediate)
      begin
        next_code  = target_in;
        next_state = rsc_pkg::RSC_IDLE;
      end
      else
      begin
        next_state = rsc_pkg::RSC_RAMP;
        next_cnt   = dwell - DW'(1);
      end
    end
    else
    begin
      case (state)
        rsc_pkg::RSC_IDLE:
          next_cnt = '0;
        rsc_pkg::RSC_RAMP:
          if (code == target)
            next_state = rsc_pkg::RSC_IDLE;
          else if (cnt == '0)
          begin
            // One code per dwell: slope is code size over dwell
            next_code = (code < target) ? code + 6'h01 : code - 6'h01;
            next_cnt  = dwell - DW'(1);
          end
          else
            next_cnt = cnt - DW'(1);
        default:
          next_state = rsc_pkg::RSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state  <= rsc_pkg::RSC_IDLE;
      target <= '0;
      // Ramps start from the rail's power-up code, not from zero
      code   <= RST_CODE;
      cnt    <= '0;
    end
    else
    begin
      state  <= next_state;
      target <= next_target;
      code   <= next_code;
      cnt    <= next_cnt;
    end
  end

  assign busy = (state == rsc_pkg::RSC_RAMP);

endmodule

// ### core/rsc_blank_timer.sv
// Purpose: Monitor blanking window, restarted by each pulse
// Assumes: CYC fits in 20 bits
// Notes:   Window is CYC cycles long from the cycle after start
`timescale 1ns/1ns
module rsc_blank_timer #(
  parameter int CYC = 250000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Control
  input  wire logic start,
  output logic      active
);

  // ==========================================================
  // Down counter
  logic [19:0] cnt;
  logic [19:0] next_cnt;

  always_comb
  begin
    if (start)
      next_cnt = 20'(CYC);
    else if (cnt != '0)
      next_cnt = cnt - 20'h0_0001;
    else
      next_cnt = cnt;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  assign active = (cnt != '0);

endmodule

// ### tb/rsc_host.sv
// Purpose: Host model driving register and set-point strobes
// Assumes: Strobes change just after mclk rises
// Notes:   Released register address and data buses carry the inverse of the last value; set-point buses hold theirs
`timescale 1ns/1ns
module rsc_host (
  // Clock
  input  wire logic          mclk,
  // Register access
  output logic [7:0]         reg_addr,
  output logic               reg_wr,
  output logic [7:0]         reg_wdata,
  output logic               reg_rd,
  input  wire logic [7:0]    reg_rdata,
  output logic               pwd_unlocked,
  // Core buck set-points
  output rsc_pkg::rsc_code_t core_buck_a_setpoint,
  output logic               core_buck_a_wr,
  output rsc_pkg::rsc_code_t core_buck_b_setpoint,
  output logic               core_buck_b_wr
);
  // ==========================================================
  // State
  logic       tight_mode;
  logic [1:0] pulse_skip;

  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    pwd_unlocked = 1'b1;
    core_buck_a_setpoint = 6'h00;
    core_buck_a_wr = 1'b0;
    core_buck_b_setpoint = 6'h00;
    core_buck_b_wr = 1'b0;
    tight_mode = 1'b1;
    pulse_skip = 2'b11;
  end

  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask

  task automatic unlock(input logic v);
    @(posedge mclk);
    pwd_unlocked <= v;
  endtask

  task automatic buck(input logic sel, input rsc_pkg::rsc_code_t v);
    rsc_pkg::rsc_code_t old;
    old = sel ? core_buck_b_setpoint : core_buck_a_setpoint;
    // Unloaded rails under a tight window could trip when lowered in pulse-skip
    if (tight_mode && v < old)
      pulse_skip = 2'b00;
    @(posedge mclk);
    core_buck_a_setpoint <= sel ? core_buck_a_setpoint : v;
    core_buck_b_setpoint <= sel ? v : core_buck_b_setpoint;
    core_buck_a_wr <= ~sel;
    core_buck_b_wr <= sel;
    @(posedge mclk);
    core_buck_a_wr <= 1'b0;
    core_buck_b_wr <= 1'b0;
  endtask
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench of the set-point slew block
// Assumes: Shortened step base and blanking counts
// Notes:   Expectations come from the counts set here
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb;
  // ==========================================================
  // Signals
  localparam int SB = 64;
  localparam int BC = 20;
  logic               mclk;
  logic               sys_rst;
  logic [7:0]         addr;
  logic               wr;
  logic [7:0]         wdata;
  logic               rd;
  logic [7:0]         rdata;
  logic               unl;
  rsc_pkg::rsc_code_t a_sp;
  logic               a_wr;
  rsc_pkg::rsc_code_t b_sp;
  logic               b_wr;
  rsc_pkg::rsc_code_t a_code;
  rsc_pkg::rsc_code_t b_code;
  logic               busy;
  rsc_pkg::rsc_code_t lin_code;
  logic [11:0]        lin_mv;
  logic               blank;
  int                 err_total;
  int                 n_checks;

  initial
  begin
    mclk = 1'b0;
    err_total = 0;
    n_checks = 0;
  end
  always #10 mclk = ~mclk;

  rsc_top #(.STEP_BASE_CYC(SB), .BLANK_CYC(BC)) u_rsc_top (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
    .reg_rd(rd), .reg_rdata(rdata), .pwd_unlocked(unl),
    .core_buck_a_setpoint(a_sp), .core_buck_a_wr(a_wr),
    .core_buck_b_setpoint(b_sp), .core_buck_b_wr(b_wr),
    .core_buck_a_code(a_code), .core_buck_b_code(b_code), .ramp_busy(busy),
    .linear_rail_code(lin_code), .linear_rail_mv(lin_mv), .linear_rail_mon_blank(blank));

  rsc_host u_rsc_host (
    .mclk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
    .reg_rdata(rdata), .pwd_unlocked(unl),
    .core_buck_a_setpoint(a_sp), .core_buck_a_wr(a_wr),
    .core_buck_b_setpoint(b_sp), .core_buck_b_wr(b_wr));

  // ==========================================================
  // Helpers
  task automatic step_wait(input int exp);
    rsc_pkg::rsc_code_t old;
    int n;
    old = a_code;
    n = 0;
    while (a_code === old && n < 300)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(n, exp);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    `CHK(busy, 1'b0);
    `CHK(lin_mv, 12'h708);
    u_rsc_host.rd(8'h1a, d);
    `CHK(d, 8'h06);
    u_rsc_host.rd(8'h1b, d);
    `CHK(d, 8'h1f);
    u_rsc_host.rd(8'h55, d);
    `CHK(d, 8'h00);
  endtask

  task automatic t_go();
    logic [7:0] d;
    u_rsc_host.wr(8'h1a, 8'h00);
    u_rsc_host.buck(1'b0, 6'h02);
    u_rsc_host.buck(1'b1, 6'h01);
    repeat (4) @(posedge mclk);
    #1;
    `CHK(a_code, 6'h00);
    u_rsc_host.wr(8'h1a, 8'h80);
    step_wait(SB);
    `CHK(b_code, 6'h01);
    `CHK(busy, 1'b1);
    u_rsc_host.rd(8'h1a, d);
    `CHK(d, 8'h80);
    step_wait(SB - 3);
    repeat (3) @(posedge mclk);
    #1;
    `CHK(busy, 1'b0);
    `CHK(lin_code, 6'h1f);
    u_rsc_host.rd(8'h1a, d);
    `CHK(d, 8'h00);
  endtask

  task automatic t_rate();
    for (int r = 0; r < 7; r++)
    begin
      u_rsc_host.buck(1'b0, a_code + 6'h01);
      u_rsc_host.wr(8'h1a, 8'(r));
      u_rsc_host.wr(8'h1a, 8'h80 | 8'(r));
      step_wait(SB >> r);
      repeat (3) @(posedge mclk);
      #1;
      `CHK(busy, 1'b0);
    end
  endtask

  task automatic t_auto();
    logic [7:0] d;
    rsc_pkg::rsc_code_t a0;
    a0 = a_code;
    u_rsc_host.wr(8'h1a, 8'h7f);
    u_rsc_host.rd(8'h1a, d);
    `CHK(d, 8'h47);
    u_rsc_host.buck(1'b1, 6'h20);
    @(posedge mclk);
    #1;
    `CHK(b_code, 6'h20);
    `CHK(a_code, a0);
    `CHK(busy, 1'b0);
    u_rsc_host.rd(8'h1a, d);
    `CHK(d, 8'h47);
    u_rsc_host.wr(8'h1a, 8'h46);
    u_rsc_host.buck(1'b0, a0 + 6'h01);
    step_wait(SB >> 6);
    `CHK(a_code, a0 + 6'h01);
  endtask

  task automatic t_lin();
    logic [7:0] d;
    logic [7:0] c[4];
    logic [11:0] mv[4];
    int n;
    c = '{8'h00, 8'h19, 8'h1a, 8'hff};
    mv = '{12'h384, 12'h5f5, 12'h60e, 12'hd48};
    u_rsc_host.unlock(1'b0);
    u_rsc_host.wr(8'h1b, 8'h05);
    repeat (3) @(posedge mclk);
    #1;
    `CHK(blank, 1'b0);
    u_rsc_host.rd(8'h1b, d);
    `CHK(d, 8'h1f);
    u_rsc_host.unlock(1'b1);
    u_rsc_host.wr(8'h1b, 8'hff);
    #1;
    n = int'(blank);
    repeat (40)
    begin
      @(posedge mclk);
      #1;
      n += int'(blank);
    end
    `CHK(n, BC);
    u_rsc_host.rd(8'h1b, d);
    `CHK(d, 8'h3f);
    for (int i = 0; i < 4; i++)
    begin
      u_rsc_host.wr(8'h1b, c[i]);
      @(posedge mclk);
      #1;
      `CHK(lin_mv, mv[i]);
    end
    `CHK(b_code, 6'h20);
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial
  begin
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_go();
    t_rate();
    t_auto();
    t_lin();
    results();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    results();
  end
endmodule
